// ==== shared/sssel_pkg.sv ====
// Package for the start-command selection logic.
// Shared by the top module and the coast-delay timer.
package sssel_pkg;
    // Stop selection setting in tenths of a second, special codes as integers
    localparam int SEL_W = 14;
    localparam logic [13:0] SEL_DECEL_SPLIT = 14'h22B8; // 8888
    localparam logic [13:0] SEL_DECEL_PAIR = 14'h270F;  // 9999
    localparam logic [13:0] SEL_LOW_MAX = 14'h03E8;     // 100.0 s in 0.1 s units
    localparam logic [13:0] SEL_HIGH_MIN = 14'h2710;    // 1000.0 s
    localparam logic [13:0] SEL_HIGH_MAX = 14'h2AF8;    // 1100.0 s
    localparam logic [13:0] SEL_RESET = 14'h270F;
    // Terminal function codes
    localparam logic [7:0] FUNC_HOLD_STOP = 8'h19;      // 25
    localparam logic [7:0] FUNC_SECOND = 8'h03;         // 3
    localparam logic [7:0] FUNC_FWD_START = 8'h3C;      // 60
    localparam logic [7:0] FUNC_REV_START = 8'h3D;      // 61
    localparam int TERM_COUNT = 7;
    // Timing: 0.1 s tick at 25 MHz
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    typedef enum logic [1:0] {DIR_STOP, DIR_FWD, DIR_REV} sssel_dir_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_COAST} sssel_state_t;
endpackage : sssel_pkg

// ==== sim/sssel_start_select_props.sv ====
// Concurrent checks on the start-command selection ports.
// Assumes function codes and setting encodings from sssel_pkg.
`timescale 1ns/100ps
module sssel_start_select_props
    import sssel_pkg::*;
#(
    parameter int TERMS = TERM_COUNT,
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [TERMS-1:0] terminalIn,
    input wire logic [TERMS*8-1:0] terminalFunc,
    input wire logic [SEL_W-1:0] stopSelectionSetting,
    input wire logic inchingRequestInput,
    input wire logic outputShutoffInput,
    input wire logic runForward,
    input wire logic runReverse,
    input wire logic decelStop,
    input wire logic coastStop,
    input wire logic outputEnable,
    input wire logic selfHoldActive,
    input wire logic secondFunctionActive,
    input wire logic settingInvalid
);
    logic holdCfg, holdIn, secIn, fwd, rev, pair, split, free;
    always_comb begin
        holdCfg = 1'b0;
        holdIn = 1'b0;
        secIn = 1'b0;
        for (int i = 0; i < TERMS; i++) begin
            if (terminalFunc[8*i+:8] == FUNC_HOLD_STOP) begin
                holdCfg = 1'b1;
                holdIn = holdIn | terminalIn[i];
            end
            if (terminalFunc[8*i+:8] == FUNC_SECOND) begin
                secIn = secIn | terminalIn[i];
            end
        end
    end
    assign fwd = terminalIn[0] && terminalFunc[7:0] == FUNC_FWD_START;
    assign rev = terminalIn[1] && terminalFunc[15:8] == FUNC_REV_START;
    assign pair = stopSelectionSetting == SEL_DECEL_PAIR || stopSelectionSetting <= SEL_LOW_MAX;
    assign split = stopSelectionSetting == SEL_DECEL_SPLIT
        || (stopSelectionSetting >= SEL_HIGH_MIN && stopSelectionSetting <= SEL_HIGH_MAX);
    assign free = !holdCfg && !outputShutoffInput && !inchingRequestInput;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_pairFwd; free && pair && fwd && !rev |=> runForward && !runReverse; endproperty
    a_pairFwd: assert property (p_pairFwd) else $error("pair forward not run");
    property p_pairBoth; free && pair && fwd && rev |=> !runForward && !runReverse; endproperty
    a_pairBoth: assert property (p_pairBoth) else $error("pair both on not stopped");
    property p_splitRev; free && split && fwd && rev |=> runReverse && !runForward; endproperty
    a_splitRev: assert property (p_splitRev) else $error("split reverse not run");
    property p_splitOff; free && split && !fwd |=> !runForward && !runReverse; endproperty
    a_splitOff: assert property (p_splitOff) else $error("split run off not stopped");
    property p_decel;
        free && stopSelectionSetting == SEL_DECEL_PAIR && runForward && !fwd && !rev
            |=> !runForward && !runReverse ##1 decelStop && !coastStop;
    endproperty
    a_decel: assert property (p_decel) else $error("withdrawal did not decelerate");
    property p_coastOff; coastStop |-> !outputEnable && !runForward && !runReverse; endproperty
    a_coastOff: assert property (p_coastOff) else $error("coasting with output on");
    property p_shutoff; outputShutoffInput |=> !outputEnable; endproperty
    a_shutoff: assert property (p_shutoff) else $error("shutoff left output on");
    property p_keepLatch;
        selfHoldActive && outputShutoffInput && holdIn && !inchingRequestInput |=> selfHoldActive;
    endproperty
    a_keepLatch: assert property (p_keepLatch) else $error("shutoff cleared latch");
    property p_release; selfHoldActive && !holdIn && !inchingRequestInput |=> !selfHoldActive;
    endproperty
    a_release: assert property (p_release) else $error("hold off kept latch");
    property p_noHoldCfg; !holdCfg |=> !selfHoldActive; endproperty
    a_noHoldCfg: assert property (p_noHoldCfg) else $error("latch without hold code");
    property p_second; 1'b1 |=> secondFunctionActive == $past(secIn); endproperty
    a_second: assert property (p_second) else $error("second function mismatch");
    c_latchRev: cover property (selfHoldActive && runReverse);
    c_coast: cover property (coastStop);
    c_decel: cover property ($rose(decelStop));
endmodule : sssel_start_select_props
bind sssel_start_select sssel_start_select_props #(.TERMS(TERMS), .TICK_LEN(TICK_LEN)) u_props (
    .clk(clk), .rst(rst), .terminalIn(terminalIn), .terminalFunc(terminalFunc),
    .stopSelectionSetting(stopSelectionSetting), .inchingRequestInput(inchingRequestInput),
    .outputShutoffInput(outputShutoffInput), .runForward(runForward), .runReverse(runReverse),
    .decelStop(decelStop), .coastStop(coastStop), .outputEnable(outputEnable),
    .selfHoldActive(selfHoldActive), .secondFunctionActive(secondFunctionActive),
    .settingInvalid(settingInvalid));

// ==== sim/sssel_terminal_model.sv ====
// Switches or controller on the input terminals.
// Levels change at falling edges only; the bench calls its tasks.
`timescale 1ns/100ps
module sssel_terminal_model
    import sssel_pkg::*;
#(
    parameter int TERMS = TERM_COUNT
) (
    input wire logic clk,
    output logic [TERMS-1:0] terminalIn
);
    initial terminalIn = '0;
    task automatic setLevel(input int idx, input logic lvl);
        @(negedge clk);
        terminalIn[idx] = lvl;
    endtask : setLevel
    task automatic setPair(input logic f, input logic r);
        @(negedge clk);
        terminalIn[1:0] = {r, f};
    endtask : setPair
    // One press then release, held for width cycles
    task automatic pulse(input int idx, input int width);
        setLevel(idx, 1'b1);
        repeat (width) @(negedge clk);
        terminalIn[idx] = 1'b0;
    endtask : pulse
endmodule : sssel_terminal_model

// ==== sim/tb_start_signal_operation_select.sv ====
// Self-checking bench for the start-command selection block.
// Short tick parameter; terminal levels come from the terminal model.
`timescale 1ns/100ps
module tb_start_signal_operation_select import sssel_pkg::*;;
    localparam int TL = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [TERM_COUNT-1:0] terminalIn;
    logic [TERM_COUNT*8-1:0] terminalFunc = '0;
    logic [SEL_W-1:0] setting = SEL_DECEL_PAIR;
    logic inching_request_input = 1'b0;
    logic shutoff = 1'b0;
    logic runFwd, runRev, decel, coast, outEn, selfHold, second, invalid;
    int err_count = 0;
    int cmp_count = 0;
    int seed = 32'h0000_530a;
    int k, n;
    logic [SEL_W-1:0] k2 [2] = '{SEL_DECEL_PAIR, SEL_DECEL_SPLIT};
    always #20 clk = ~clk;
    sssel_terminal_model MODEL (.clk(clk), .terminalIn(terminalIn));
    sssel_start_select #(.TICK_LEN(TL)) DUT (.clk(clk), .rst(rst), .terminalIn(terminalIn),
        .terminalFunc(terminalFunc), .stopSelectionSetting(setting),
        .inchingRequestInput(inching_request_input), .outputShutoffInput(shutoff), .runForward(runFwd),
        .runReverse(runRev), .decelStop(decel), .coastStop(coast), .outputEnable(outEn),
        .selfHoldActive(selfHold), .secondFunctionActive(second), .settingInvalid(invalid));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done();
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic cyc(input int c);
        repeat (c) @(negedge clk);
    endtask : cyc
    function automatic logic [1:0] expRun(input logic f, input logic r, input logic sp);
        if (sp) begin
            return f ? {r, ~r} : 2'b00;
        end
        return (f ^ r) ? {r, f} : 2'b00;
    endfunction : expRun
    // Run forward, withdraw, then time the delay until coasting
    task automatic coastTime(input logic [SEL_W-1:0] s, input int ticks);
        @(negedge clk);
        setting = s;
        MODEL.setPair(1'b1, 1'b0);
        cyc(3);
        check("runFwd", runFwd, 1'b1);
        MODEL.setPair(1'b0, 1'b0);
        n = 0;
        while (coast !== 1'b1 && n < ticks * TL + 20) begin
            @(negedge clk);
            n++;
            if (n == 2) check("decelFirst", decel, 1'b1);
        end
        if (coast !== 1'b1) begin
            err_count++;
            test_done();
        end
        check("delay", n >= ticks * TL - 4 && n <= ticks * TL + 4, 1'b1);
        check("coastOut", outEn, 1'b0);
    endtask : coastTime
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        test_done();
    end
    initial begin
        terminalFunc[7:0] = FUNC_FWD_START;
        terminalFunc[15:8] = FUNC_REV_START;
        terminalFunc[31:24] = FUNC_SECOND;
        cyc(5);
        rst = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            k = $random(seed);
            case (k[1:0])
                2'd0: setting = SEL_DECEL_PAIR;
                2'd1: setting = SEL_DECEL_SPLIT;
                2'd2: setting = 14'(k[23:8] % (SEL_LOW_MAX + 14'h0001));
                default: setting = SEL_HIGH_MIN + 14'(k[23:8] % 16'h03E9);
            endcase
            MODEL.setLevel(3, k[4]);
            MODEL.setPair(k[2], k[3]);
            cyc(2);
            check("run", {runRev, runFwd}, expRun(k[2], k[3], k[0]));
            check("second", second, k[4]);
            check("valid", invalid, 1'b0);
        end
        coastTime(14'h0032, 50);
        coastTime(14'h2724, 20);
        foreach (k2[j]) begin
            @(negedge clk);
            setting = k2[j];
            MODEL.setPair(1'b1, 1'b0);
            cyc(3);
            MODEL.setPair(1'b0, 1'b0);
            cyc(60);
            check("noCoast", {decel, coast}, 2'b10);
        end
        @(negedge clk);
        setting = 14'h1388;
        cyc(2);
        check("invalid", invalid, 1'b1);
        @(negedge clk);
        setting = SEL_DECEL_PAIR;
        terminalFunc[23:16] = FUNC_HOLD_STOP;
        MODEL.setLevel(2, 1'b1);
        MODEL.pulse(0, 3);
        cyc(3);
        check("latchFwd", {selfHold, runFwd}, 2'b11);
        MODEL.pulse(1, 1);
        cyc(3);
        check("latchRev", {runRev, runFwd}, 2'b10);
        shutoff = 1'b1;
        cyc(3);
        check("shutoff", {outEn, selfHold}, 2'b01);
        shutoff = 1'b0;
        cyc(3);
        check("resume", {outEn, runRev}, 2'b11);
        MODEL.setLevel(2, 1'b0);
        cyc(3);
        check("release", {decel, selfHold, runRev}, 3'b100);
        inching_request_input = 1'b1;
        MODEL.setLevel(2, 1'b1);
        MODEL.pulse(0, 3);
        cyc(3);
        check("jogHold", selfHold, 1'b0);
        inching_request_input = 1'b0;
        terminalFunc[23:16] = 8'h00;
        MODEL.pulse(0, 3);
        cyc(3);
        check("noCode", {selfHold, runFwd}, 2'b00);
        terminalFunc[23:16] = FUNC_FWD_START;
        cyc(3);
        check("wrongTerm", runFwd, 1'b0);
        test_done();
    end
endmodule : tb_start_signal_operation_select

// ==== verilog/sssel_coast_timer.sv ====
// Coast delay timer counting 0.1 s ticks.
// Load pulse starts it; clear aborts it; done pulses once at expiry.
`timescale 1ns/100ps
module sssel_coast_timer
    import sssel_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic clear,
    input wire logic [SEL_W-1:0] loadValue,
    output logic busy,
    output logic done
);
    logic [24:0] tickCount;
    logic [SEL_W-1:0] remain;
    logic [24:0] next_tickCount;
    logic [SEL_W-1:0] next_remain;
    logic next_busy;
    logic next_done;

    always_comb begin
        next_tickCount = tickCount;
        next_remain = remain;
        next_busy = busy;
        next_done = 1'b0;
        if (clear) begin
            next_busy = 1'b0;
        end else if (load) begin
            next_busy = 1'b1;
            next_remain = loadValue;
            next_tickCount = '0;
        end else if (busy) begin
            if (remain == '0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else if (tickCount == 25'(TICK_LEN - 1)) begin
                next_tickCount = '0;
                next_remain = remain - 1'b1;
            end else begin
                next_tickCount = tickCount + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCount <= '0;
            remain <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            tickCount <= next_tickCount;
            remain <= next_remain;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule : sssel_coast_timer

// ==== verilog/sssel_start_select.sv ====
// Start-command decoding, stop-method selection and three-wire self-hold.
// Inputs are synchronous levels from the input terminals; settings are static ports.
//
// Functional notes
// - Timed settings 0-100 s and 1000-1100 s coast after start removal.
// - Upper timed range: coast delay is setting minus 1000 s, split scheme.
// - Settings 9999 and 8888 decelerate to stop on start removal.
// - 9999 and low range: forward alone fwd, reverse alone rev, else stop.
// - 8888 and upper range: forward is run, reverse is direction.
// - Hold input on enables self-hold; start inputs only trigger.
// - Start pulse on then off keeps latched command running.
// - Hold input off releases latch and decelerates to stop.
// - Hold function only active if some terminal has function code 25.
// - Hold input taken only from a physical terminal.
// - Inching request on makes hold input ignored.
// - Output shutoff stops output but keeps the self-hold latch.
// - Forward start only on terminal 0, reverse start only on terminal 1.
// - Terminal function chosen by code; second function uses code 3.
`timescale 1ns/100ps
module sssel_start_select
    import sssel_pkg::*;
#(
    parameter int TERMS = TERM_COUNT,
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [TERMS-1:0] terminalIn,
    input wire logic [TERMS*8-1:0] terminalFunc,
    input wire logic [SEL_W-1:0] stopSelectionSetting,
    input wire logic inchingRequestInput,
    input wire logic outputShutoffInput,
    output logic runForward,
    output logic runReverse,
    output logic decelStop,
    output logic coastStop,
    output logic outputEnable,
    output logic selfHoldActive,
    output logic secondFunctionActive,
    output logic settingInvalid
);
    logic [1:0] runDir;
    logic holdLatch;
    logic [1:0] latchedDir;
    logic prevFwd;
    logic prevRev;
    sssel_state_t state;
    logic [1:0] next_runDir;
    logic next_holdLatch;
    logic [1:0] next_latchedDir;
    sssel_state_t next_state;
    logic next_decel;
    logic next_coast;
    logic next_oe;
    logic next_second;
    logic next_invalid;

    logic forwardStartInput;
    logic reverseStartInput;
    logic holdStopInput;
    logic secondFunctionInput;
    logic holdAssigned;
    logic lowRange;
    logic highRange;
    logic splitScheme;
    logic coastMode;
    logic [1:0] cmdDir;
    logic timerLoad;
    logic timerClear;
    logic timerBusy;
    logic [SEL_W-1:0] delayValue;
    logic holdOn;
    logic [1:0] effDir;
    logic next_prevFwd;
    logic next_prevRev;
    logic next_runForward;
    logic next_runReverse;
    logic next_selfHold;

    function automatic logic [7:0] funcOf(input logic [TERMS*8-1:0] f, input int idx);
        funcOf = f[idx*8 +: 8];
    endfunction : funcOf

    // Any terminal holding a given function code, OR of its levels
    function automatic logic anyWith(input logic [TERMS*8-1:0] f, input logic [TERMS-1:0] t,
                                     input logic [7:0] code);
        anyWith = 1'b0;
        for (int i = 0; i < TERMS; i++) begin
            if (funcOf(f, i) == code) begin
                anyWith = anyWith | t[i];
            end
        end
    endfunction : anyWith

    function automatic logic hasFunc(input logic [TERMS*8-1:0] f, input logic [7:0] code);
        hasFunc = 1'b0;
        for (int i = 0; i < TERMS; i++) begin
            if (funcOf(f, i) == code) begin
                hasFunc = 1'b1;
            end
        end
    endfunction : hasFunc

    always_comb begin
        // Start functions live on fixed terminals only
        forwardStartInput = (funcOf(terminalFunc, 0) == FUNC_FWD_START) & terminalIn[0];
        reverseStartInput = (funcOf(terminalFunc, 1) == FUNC_REV_START) & terminalIn[1];
        holdAssigned = hasFunc(terminalFunc, FUNC_HOLD_STOP);
        holdStopInput = anyWith(terminalFunc, terminalIn, FUNC_HOLD_STOP);
        secondFunctionInput = anyWith(terminalFunc, terminalIn, FUNC_SECOND);
    end

    // Stop method and input scheme from the setting
    always_comb begin
        lowRange = stopSelectionSetting <= SEL_LOW_MAX;
        highRange = (stopSelectionSetting >= SEL_HIGH_MIN) && (stopSelectionSetting <= SEL_HIGH_MAX);
        splitScheme = highRange || (stopSelectionSetting == SEL_DECEL_SPLIT);
        coastMode = lowRange || highRange;
        delayValue = highRange ? SEL_W'(stopSelectionSetting - SEL_HIGH_MIN)
                               : stopSelectionSetting;
        if (splitScheme) begin
            if (!forwardStartInput) begin
                cmdDir = DIR_STOP;
            end else begin
                cmdDir = reverseStartInput ? DIR_REV : DIR_FWD;
            end
        end else begin
            case ({forwardStartInput, reverseStartInput})
                2'b10: cmdDir = DIR_FWD;
                2'b01: cmdDir = DIR_REV;
                default: cmdDir = DIR_STOP;
            endcase
        end
    end

    // Previous start levels for the trigger edges of the self-hold
    always_comb begin
        next_prevFwd = forwardStartInput;
        next_prevRev = reverseStartInput;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevFwd <= 1'b0;
            prevRev <= 1'b0;
        end else begin
            prevFwd <= next_prevFwd;
            prevRev <= next_prevRev;
        end
    end

    // Three-wire latch; jog or a missing hold code disables it
    always_comb begin
        logic fwdRise;
        logic revRise;
        fwdRise = forwardStartInput && !prevFwd;
        revRise = reverseStartInput && !prevRev;
        holdOn = holdAssigned && holdStopInput && !inchingRequestInput;
        next_holdLatch = holdLatch;
        next_latchedDir = latchedDir;
        if (!holdOn) begin
            next_holdLatch = 1'b0;
            next_latchedDir = DIR_STOP;
        end else begin
            // Start inputs only trigger; latch survives their release
            if (fwdRise && !revRise) begin
                next_holdLatch = 1'b1;
                next_latchedDir = DIR_FWD;
            end else if (revRise && !fwdRise) begin
                next_holdLatch = 1'b1;
                next_latchedDir = DIR_REV;
            end
        end
        // Shutoff does not touch the latch
        effDir = holdOn ? (next_holdLatch ? next_latchedDir : DIR_STOP) : cmdDir;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            holdLatch <= 1'b0;
            latchedDir <= DIR_STOP;
        end else begin
            holdLatch <= next_holdLatch;
            latchedDir <= next_latchedDir;
        end
    end

    // Run state; the stop method is chosen when the command drops
    always_comb begin
        next_state = state;
        next_runDir = runDir;
        next_decel = 1'b0;
        next_coast = 1'b0;
        timerLoad = 1'b0;
        timerClear = 1'b0;
        case (state)
            ST_IDLE: begin
                if (effDir != DIR_STOP) begin
                    next_state = ST_RUN;
                    next_runDir = effDir;
                end
            end
            ST_RUN: begin
                if (effDir == DIR_STOP) begin
                    next_runDir = DIR_STOP;
                    if (coastMode && !(holdAssigned && holdLatch && !holdOn)) begin
                        next_state = ST_COAST;
                        timerLoad = 1'b1;
                    end else begin
                        next_state = ST_DECEL;
                    end
                end else begin
                    next_runDir = effDir;
                end
            end
            ST_DECEL: begin
                // Holds until a new start; stop completion is judged outside
                next_decel = 1'b1;
                next_runDir = DIR_STOP;
                if (effDir != DIR_STOP) begin
                    next_state = ST_RUN;
                    next_runDir = effDir;
                end
            end
            ST_COAST: begin
                // Decelerate until the delay lapses, then free-run
                next_runDir = DIR_STOP;
                if (effDir != DIR_STOP) begin
                    timerClear = 1'b1;
                    next_state = ST_RUN;
                    next_runDir = effDir;
                end else if (timerBusy) begin
                    next_decel = 1'b1;
                end else begin
                    next_coast = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_runDir = DIR_STOP;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            runDir <= DIR_STOP;
        end else begin
            state <= next_state;
            runDir <= next_runDir;
        end
    end

    // Output values, registered below so every port leaves a flip-flop
    always_comb begin
        next_runForward = next_runDir == DIR_FWD;
        next_runReverse = next_runDir == DIR_REV;
        next_selfHold = next_holdLatch;
        next_oe = !outputShutoffInput && !next_coast;
        next_second = secondFunctionInput;
        next_invalid = !(coastMode || stopSelectionSetting == SEL_DECEL_PAIR
                         || stopSelectionSetting == SEL_DECEL_SPLIT);
    end

    // Coast delay in 0.1 s ticks, restarted on each withdrawal
    sssel_coast_timer #(
        .TICK_LEN(TICK_LEN)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .load(timerLoad),
        .clear(timerClear),
        .loadValue(delayValue),
        .busy(timerBusy),
        .done()
    );

    // Registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runForward <= 1'b0;
            runReverse <= 1'b0;
            decelStop <= 1'b0;
            coastStop <= 1'b0;
            outputEnable <= 1'b0;
            selfHoldActive <= 1'b0;
            secondFunctionActive <= 1'b0;
            settingInvalid <= 1'b0;
        end else begin
            runForward <= next_runForward;
            runReverse <= next_runReverse;
            decelStop <= next_decel;
            coastStop <= next_coast;
            outputEnable <= next_oe;
            selfHoldActive <= next_selfHold;
            secondFunctionActive <= next_second;
            settingInvalid <= next_invalid;
        end
    end
endmodule : sssel_start_select
